/* hw/srt_relay_timer.sv */
`timescale 1ns/10ps
`default_nettype none
// How it works
// - relay one forced off when setpoint one is in pid mode and cycle time is zero
// - flash display while a comparator-mode setpoint with flashing is active
// - tracking allowed only for hysteresis, deviation or pid setpoints
// - tracked threshold is master value plus signed offset, kept current
// - tracking uses the master value only, own modes kept
// - energize digit zero relay on above, digit one relay on below
// - tracking select off or master number one to six
// - each relay runs one of seven timer modes
// - delays counted in tenth second ticks, sixteen bits
// - setpoints one and two may pick millisecond ticks for pulse, repeat
// - third digit codes latching, reset and setup choices
// - pid on setpoint one bypasses its timers
// - normal mode energizes only after full make delay
// - normal mode holds relay for break delay after deactivation
// - zero delay means relay follows setpoint directly
// - repeat on cycles on then off while active, drops at once
// - pulse on gives full pulse after make delay, needs rearm
// - one-shot on holds at least minimum on time, longer while active
// - pulsed-off modes rest energized, pulse off on deactivation
// - one-shot off: break delay, then full minimum off time
// - repeat off alternates off then on while inactive
module srt_relay_timer
  import srt_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [NUM_SP-1:0] i_sp_above,
  input wire logic [NUM_SP-1:0] i_energize_below,
  input wire logic [NUM_SP*3-1:0] i_timer_mode,
  input wire logic [NUM_SP*2-1:0] i_ctrl_mode,
  input wire logic [NUM_SP*3-1:0] i_third_digit,
  input wire logic [NUM_SP-1:0] i_flash_en,
  input wire logic [1:0] i_fine_res,
  input wire logic [NUM_SP*DLY_W-1:0] i_make_delay,
  input wire logic [NUM_SP*DLY_W-1:0] i_break_delay,
  input wire logic [NUM_SP*DLY_W-1:0] i_on_time,
  input wire logic [NUM_SP*DLY_W-1:0] i_off_time,
  input wire logic [15:0] i_cycle_time,
  input wire logic i_pid_drive,
  input wire logic [NUM_SP*VAL_W-1:0] i_own_point,
  input wire logic [NUM_SP*VAL_W-1:0] i_offset,
  input wire logic [NUM_SP*3-1:0] i_track_sel,
  output logic [NUM_SP*VAL_W-1:0] o_threshold_point,
  output logic [NUM_SP-1:0] o_sp_active,
  output logic [NUM_SP-1:0] o_relay,
  output logic o_display_blank,
  output logic [NUM_SP-1:0] o_timer_setup,
  output logic [NUM_SP-1:0] o_comparator_setup
);
  typedef enum logic [1:0] {PH_IDLE, PH_DELAY, PH_HOLD, PH_GAP} srt_phase_t;
  typedef struct packed {
    srt_phase_t [NUM_SP-1:0] ph;
    logic [NUM_SP-1:0][DLY_W-1:0] cnt;
    logic [NUM_SP-1:0] act_d;
    logic [NUM_SP-1:0] relay;
    logic [NUM_SP-1:0] act;
    logic [DLY_W-1:0] fcnt;
    logic blank;
    logic [NUM_SP-1:0] tsetup;
    logic [NUM_SP-1:0] csetup;
  } srt_st_t;
  srt_st_t st, next_st;
  logic tick_coarse;
  logic tick_fine;
  logic [NUM_SP-1:0] act;
  srt_tick #(.PERIOD(TICK_COARSE_CYC)) u_tick_coarse (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .o_tick(tick_coarse)
  );
  srt_tick #(.PERIOD(TICK_FINE_CYC)) u_tick_fine (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .o_tick(tick_fine)
  );
  srt_track u_track (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_own_point(i_own_point),
    .i_offset(i_offset),
    .i_track_sel(i_track_sel),
    .i_ctrl_mode(i_ctrl_mode),
    .o_threshold_point(o_threshold_point)
  );
  assign act = i_sp_above ^ i_energize_below;
  always_comb begin
    srt_tmode_t tm;
    logic tk;
    logic a;
    logic rise;
    logic fall;
    logic [DLY_W-1:0] mk;
    logic [DLY_W-1:0] bk;
    logic [DLY_W-1:0] on_t;
    logic [DLY_W-1:0] off_t;
    logic [DLY_W-1:0] c;
    logic done;
    logic any_flash;
    tm = TM_NORMAL;
    tk = 1'b0;
    a = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    mk = '0;
    bk = '0;
    on_t = '0;
    off_t = '0;
    c = '0;
    done = 1'b0;
    any_flash = 1'b0;
    next_st = st;
    next_st.act_d = act;
    next_st.act = act;
    for (int i = 0; i < NUM_SP; i++) begin
      tm = srt_tmode_t'(i_timer_mode[i*3 +: 3]);
      a = act[i];
      rise = a & ~st.act_d[i];
      fall = ~a & st.act_d[i];
      mk = i_make_delay[i*DLY_W +: DLY_W];
      bk = i_break_delay[i*DLY_W +: DLY_W];
      on_t = i_on_time[i*DLY_W +: DLY_W];
      off_t = i_off_time[i*DLY_W +: DLY_W];
      // coarse tick; fine tick on first two for pulse/repeat
      tk = tick_coarse;
      if (i < 2 && i_fine_res[i] && (tm == TM_REPEAT_ON || tm == TM_PULSE_ON ||
          tm == TM_REPEAT_OFF || tm == TM_PULSE_OFF)) begin
        tk = tick_fine;
      end
      c = st.cnt[i];
      if (tk && c != DLY_ZERO) begin
        c = c - 1'b1;
      end
      done = (c == DLY_ZERO);
      next_st.cnt[i] = c;
      unique case (tm)
        TM_NORMAL: begin
          if (a && !st.relay[i]) begin
            if (rise) begin
              next_st.cnt[i] = mk;
            end
            if ((rise && mk == DLY_ZERO) || (!rise && done)) begin
              next_st.relay[i] = 1'b1;
            end
          end else if (!a && st.relay[i]) begin
            if (fall) begin
              next_st.cnt[i] = bk;
            end
            if ((fall && bk == DLY_ZERO) || (!fall && done)) begin
              next_st.relay[i] = 1'b0;
            end
          end
        end
        TM_REPEAT_ON, TM_REPEAT_OFF: begin
          // cycle in the cycling state, steady in the other
          if (a == (tm == TM_REPEAT_ON)) begin
            if (a ^ st.act_d[i]) begin
              next_st.relay[i] = (tm == TM_REPEAT_ON);
              next_st.cnt[i] = (tm == TM_REPEAT_ON) ? on_t : off_t;
            end else if (done) begin
              next_st.relay[i] = ~st.relay[i];
              next_st.cnt[i] = st.relay[i] ? off_t : on_t;
            end
          end else begin
            next_st.relay[i] = (tm == TM_REPEAT_OFF);
          end
        end
        TM_PULSE_ON, TM_ONESHOT_ON, TM_PULSE_OFF, TM_ONESHOT_OFF: begin
          if (tm == TM_PULSE_ON || tm == TM_ONESHOT_ON) begin
            if (st.ph[i] == PH_IDLE) begin
              next_st.relay[i] = 1'b0;
            end
          end else if (st.ph[i] == PH_IDLE) begin
            next_st.relay[i] = 1'b1;
          end
          unique case (st.ph[i])
            PH_IDLE: begin
              if ((tm == TM_PULSE_ON || tm == TM_ONESHOT_ON) ? rise : fall) begin
                next_st.ph[i] = PH_DELAY;
                next_st.cnt[i] = (tm == TM_PULSE_ON || tm == TM_ONESHOT_ON) ? mk : bk;
              end
            end
            PH_DELAY: begin
              if ((tm == TM_PULSE_ON || tm == TM_ONESHOT_ON) ? !a : a) begin
                next_st.ph[i] = PH_IDLE;
              end else if (done) begin
                next_st.ph[i] = PH_HOLD;
                next_st.relay[i] = (tm == TM_PULSE_ON || tm == TM_ONESHOT_ON);
                next_st.cnt[i] = (tm == TM_PULSE_ON || tm == TM_ONESHOT_ON) ? on_t : off_t;
              end
            end
            PH_HOLD: begin
              if (done) begin
                next_st.ph[i] = PH_GAP;
              end
            end
            PH_GAP: begin
              // one-shot extends while still in its state
              if (tm == TM_ONESHOT_ON && a) begin
                next_st.relay[i] = 1'b1;
              end else if (tm == TM_ONESHOT_OFF && !a) begin
                next_st.relay[i] = 1'b0;
              end else begin
                next_st.relay[i] = (tm == TM_PULSE_OFF || tm == TM_ONESHOT_OFF);
              end
              if ((tm == TM_PULSE_ON || tm == TM_ONESHOT_ON) ? !a : a) begin
                next_st.ph[i] = PH_IDLE;
              end
            end
          endcase
        end
        default: begin
          next_st.relay[i] = a;
        end
      endcase
      // pid on setpoint one ignores timers
      if (i == 0 && i_ctrl_mode[1:0] == CM_PID) begin
        next_st.relay[i] = i_pid_drive;
        next_st.ph[i] = PH_IDLE;
      end
      // flash only for comparator modes with flashing
      if (a && i_flash_en[i] && (i_ctrl_mode[i*2 +: 2] == CM_HYST ||
          i_ctrl_mode[i*2 +: 2] == CM_DEV)) begin
        any_flash = 1'b1;
      end
      next_st.tsetup[i] = (i_third_digit[i*3 +: 3] == D3_TIMER_SETUP);
      next_st.csetup[i] = (i_third_digit[i*3 +: 3] == D3_COMPARATOR_SETUP);
    end
    // relay one off with pid on setpoint one and zero cycle time
    if (i_ctrl_mode[1:0] == CM_PID && i_cycle_time == CYCLE_ZERO) begin
      next_st.relay[0] = 1'b0;
    end
    if (!any_flash) begin
      next_st.blank = 1'b0;
      next_st.fcnt = FLASH_HALF_TICKS;
    end else if (tick_coarse) begin
      if (st.fcnt == DLY_ZERO) begin
        next_st.blank = ~st.blank;
        next_st.fcnt = FLASH_HALF_TICKS;
      end else begin
        next_st.fcnt = st.fcnt - 1'b1;
      end
    end
  end
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign o_relay = st.relay;
  assign o_sp_active = st.act;
  assign o_display_blank = st.blank;
  assign o_timer_setup = st.tsetup;
  assign o_comparator_setup = st.csetup;

  chk_relay1_cycle_off: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_ctrl_mode[1:0] == CM_PID && i_cycle_time == CYCLE_ZERO) |=> !o_relay[0])
    else $error("relay one on with zero cycle time");
  // no flashing without an active flashing setpoint
  chk_flash_stop: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    ((act & i_flash_en) == '0) |=> !o_display_blank)
    else $error("display blank with no flashing setpoint");
  chk_zero_follow: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_timer_mode[5:3] == 3'h0 && i_make_delay[31:16] == DLY_ZERO &&
     $rose(act[1])) |=> o_relay[1])
    else $error("zero make delay not instant");
  chk_repeat_drop: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_timer_mode[5:3] == 3'h1 && !act[1] && !st.act_d[1]) |=> !o_relay[1])
    else $error("repeat on relay held while inactive");
  chk_repeat_off_on: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_timer_mode[5:3] == 3'h4 && act[1]) |=> o_relay[1])
    else $error("repeat off relay not on while active");
  chk_setup_decode: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_third_digit[2:0] == D3_TIMER_SETUP) |=> o_timer_setup[0] && !o_comparator_setup[0])
    else $error("timer setup digit not decoded");
  // relay still off the cycle after activation with make delay above one
  chk_make_wait: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_timer_mode[5:3] == 3'h0 && i_make_delay[31:16] > 16'h0001 &&
     $rose(act[1]) && !o_relay[1]) |=> !o_relay[1])
    else $error("relay energized before make delay");
  // pid setpoint one follows pid drive
  chk_pid_bypass: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_ctrl_mode[1:0] == CM_PID && i_cycle_time != CYCLE_ZERO) |=> o_relay[0] == $past(i_pid_drive))
    else $error("pid drive not passed to relay one");
endmodule
`default_nettype wire

/* pkg/srt_pkg.sv */
`default_nettype none
package srt_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  // timebase steps
  localparam real STEP_COARSE_S = 0.1;
  localparam real STEP_FINE_S = 0.001;
  localparam int unsigned TICK_COARSE_CYC = int'(STEP_COARSE_S * CLK_HZ);
  localparam int unsigned TICK_FINE_CYC = int'(STEP_FINE_S * CLK_HZ);
  localparam int unsigned NUM_SP = 6;
  localparam int unsigned DLY_W = 16;
  localparam int unsigned VAL_W = 17;
  localparam int unsigned DIV_W = 24;
  // one less than the flashing half period in coarse ticks
  localparam logic [DLY_W-1:0] FLASH_HALF_TICKS = 16'h0005;
  localparam logic [DLY_W-1:0] DLY_ZERO = 16'h0000;
  localparam logic [15:0] CYCLE_ZERO = 16'h0000;
  // third configuration digit
  localparam logic [2:0] D3_NO_LATCH = 3'h0;
  localparam logic [2:0] D3_LATCHED = 3'h1;
  localparam logic [2:0] D3_MANUAL = 3'h2;
  localparam logic [2:0] D3_LATCH_MANUAL = 3'h3;
  localparam logic [2:0] D3_LATCH_OFF = 3'h4;
  localparam logic [2:0] D3_COMPARATOR_SETUP = 3'h5;
  localparam logic [2:0] D3_TIMER_SETUP = 3'h6;
  // control modes
  localparam logic [1:0] CM_HYST = 2'h0;
  localparam logic [1:0] CM_DEV = 2'h1;
  localparam logic [1:0] CM_PID = 2'h2;
  localparam logic [1:0] CM_TIMER = 2'h3;
  // tracking selection, 0 = off
  localparam logic [2:0] TRK_OFF = 3'h0;
  localparam logic [2:0] TRK_MAX = 3'h6;
  typedef enum logic [2:0] {
    TM_NORMAL, TM_REPEAT_ON, TM_PULSE_ON, TM_ONESHOT_ON,
    TM_REPEAT_OFF, TM_PULSE_OFF, TM_ONESHOT_OFF
  } srt_tmode_t;
endpackage
`default_nettype wire

/* hw/srt_tick.sv */
`timescale 1ns/10ps
`default_nettype none
module srt_tick
  import srt_pkg::*;
#(
  parameter int unsigned PERIOD = 10
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  output logic o_tick
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } srt_tick_st_t;
  srt_tick_st_t st, next_st;
  localparam logic [DIV_W-1:0] LAST = DIV_W'(PERIOD - 1);
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == LAST) begin
      next_st.cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign o_tick = st.tick;
endmodule
`default_nettype wire

/* hw/srt_track.sv */
`timescale 1ns/10ps
`default_nettype none
module srt_track
  import srt_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [NUM_SP*VAL_W-1:0] i_own_point,
  input wire logic [NUM_SP*VAL_W-1:0] i_offset,
  input wire logic [NUM_SP*3-1:0] i_track_sel,
  input wire logic [NUM_SP*2-1:0] i_ctrl_mode,
  output logic [NUM_SP*VAL_W-1:0] o_threshold_point
);
  typedef struct packed {
    logic [NUM_SP*VAL_W-1:0] thr;
  } srt_track_st_t;
  srt_track_st_t st, next_st;
  always_comb begin
    logic [2:0] sel;
    logic [1:0] md;
    logic [VAL_W-1:0] master;
    sel = '0;
    md = '0;
    master = '0;
    next_st = st;
    for (int i = 0; i < NUM_SP; i++) begin
      sel = i_track_sel[i*3 +: 3];
      md = i_ctrl_mode[i*2 +: 2];
      next_st.thr[i*VAL_W +: VAL_W] = i_own_point[i*VAL_W +: VAL_W];
      // tracking only in comparator or pid modes
      // selection one through six names the master
      if (sel != TRK_OFF && sel <= TRK_MAX && md != CM_TIMER) begin
        // only the master's absolute value is used
        master = i_own_point[(32'(sel) - 1) * VAL_W +: VAL_W];
        // master plus signed offset, every cycle
        next_st.thr[i*VAL_W +: VAL_W] = master + i_offset[i*VAL_W +: VAL_W];
      end
    end
  end
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign o_threshold_point = st.thr;
endmodule
`default_nettype wire

/* tb/srt_plant.sv */
`timescale 1ns/10ps
`default_nettype none
module srt_plant (
  input wire logic i_core_clk,
  input wire logic [srt_pkg::VAL_W-1:0] i_level,
  input wire logic [srt_pkg::NUM_SP*srt_pkg::VAL_W-1:0] i_threshold_point,
  output logic [srt_pkg::NUM_SP-1:0] o_sp_above
);
  import srt_pkg::*;
  // comparator bank, one clock of latency like the real front end
  // at or above
  always_ff @(posedge i_core_clk) begin
    for (int i = 0; i < NUM_SP; i++) begin
      o_sp_above[i] <= i_level >= i_threshold_point[i*VAL_W +: VAL_W];
    end
  end
endmodule
`default_nettype wire

/* tb/srt_relay_timer_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module srt_relay_timer_tb;
  import srt_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [VAL_W-1:0] lvl = '0;
  logic [NUM_SP-1:0] ab, act, rly, tsu, csu;
  logic [NUM_SP-1:0] bel = '0;
  logic [NUM_SP-1:0] fl = '0;
  logic [NUM_SP*3-1:0] tm = '0;
  logic [NUM_SP*3-1:0] d3 = '0;
  logic [NUM_SP*3-1:0] ts = '0;
  logic [NUM_SP*2-1:0] cm = '0;
  logic [1:0] fr = '0;
  logic [NUM_SP*DLY_W-1:0] mk = '0;
  logic [NUM_SP*DLY_W-1:0] bk = '0;
  logic [NUM_SP*DLY_W-1:0] on = '0;
  logic [NUM_SP*DLY_W-1:0] of = '0;
  logic [15:0] cyc = '0;
  logic pid = 1'b0;
  logic blank;
  logic [NUM_SP*VAL_W-1:0] own = '0;
  logic [NUM_SP*VAL_W-1:0] ofs = '0;
  logic [NUM_SP*VAL_W-1:0] thr;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  srt_relay_timer dut (.i_core_clk(clk), .i_resetn(rstn), .i_sp_above(ab),
    .i_energize_below(bel), .i_timer_mode(tm), .i_ctrl_mode(cm), .i_third_digit(d3),
    .i_flash_en(fl), .i_fine_res(fr), .i_make_delay(mk), .i_break_delay(bk),
    .i_on_time(on), .i_off_time(of), .i_cycle_time(cyc), .i_pid_drive(pid),
    .i_own_point(own), .i_offset(ofs), .i_track_sel(ts), .o_threshold_point(thr),
    .o_sp_active(act), .o_relay(rly), .o_display_blank(blank), .o_timer_setup(tsu),
    .o_comparator_setup(csu));

  srt_plant plant (.i_core_clk(clk), .i_level(lvl), .i_threshold_point(thr),
    .o_sp_above(ab));

  task automatic test_done;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [VAL_W-1:0] e, input logic [VAL_W-1:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rst;
    @(posedge clk);
    rstn <= 1'b0;
    tm <= '0;
    cm <= {NUM_SP{CM_TIMER}};
    d3 <= '0;
    ts <= '0;
    bel <= '0;
    fl <= '0;
    mk <= '0;
    bk <= '0;
    on <= '0;
    of <= '0;
    cyc <= 16'h0001;
    pid <= 1'b0;
    ofs <= '0;
    lvl <= '0;
    for (int i = 0; i < NUM_SP; i++) begin
      own[i*VAL_W +: VAL_W] <= 17'h64 * VAL_W'(i + 1);
    end
    repeat (20) @(posedge clk);
    chk("relay in reset", '0, VAL_W'(rly));
    chk("active in reset", '0, VAL_W'(act));
    rstn <= 1'b1;
    @(posedge clk);
  endtask

  task automatic lv(input logic [VAL_W-1:0] x);
    @(posedge clk);
    lvl <= x;
  endtask

  // wait a bounded time for a relay level
  task automatic wr(input int sp, input logic v, input int n);
    int k;
    k = 0;
    @(negedge clk);
    while (rly[sp] !== v && k < n) begin
      @(negedge clk);
      k++;
    end
    chk("relay", VAL_W'(v), VAL_W'(rly[sp]));
  endtask

  // relay must keep one level for n cycles
  task automatic hd(input int sp, input logic v, input int n);
    logic bad;
    bad = 1'b0;
    repeat (n) begin
      @(negedge clk);
      if (rly[sp] !== v) bad = 1'b1;
    end
    chk("relay held", VAL_W'(v), VAL_W'(bad ? ~v : v));
  endtask

  task automatic t_decode;
    for (int d = 0; d < 7; d++) begin
      @(posedge clk);
      d3 <= {NUM_SP{3'(d)}};
      repeat (3) @(negedge clk);
      chk("timer setup", VAL_W'({NUM_SP{d == 6}}), VAL_W'(tsu));
      chk("comparator setup", VAL_W'({NUM_SP{d == 5}}), VAL_W'(csu));
    end
    $display("decode test done");
  endtask

  task automatic t_track;
    rst();
    @(posedge clk);
    cm <= {CM_HYST, CM_HYST, CM_HYST, CM_DEV, CM_PID, CM_HYST};
    ts[5:3] <= 3'h1;
    ts[8:6] <= 3'h1;
    ofs[33:17] <= 17'h5;
    ofs[50:34] <= 17'h1fff1;
    repeat (3) @(negedge clk);
    chk("tracked sp2", 17'h69, thr[33:17]);
    chk("tracked sp3", 17'h55, thr[50:34]);
    @(posedge clk);
    own[16:0] <= 17'h6e;
    repeat (3) @(negedge clk);
    chk("retracked sp2", 17'h73, thr[33:17]);
    chk("retracked sp3", 17'h5f, thr[50:34]);
    @(posedge clk);
    cm[5:4] <= CM_TIMER;
    ts[5:3] <= 3'h7;
    repeat (3) @(negedge clk);
    chk("timer mode sp3", 17'h12c, thr[50:34]);
    chk("bad select sp2", 17'hc8, thr[33:17]);
    for (int k = 1; k < 6; k++) begin
      @(posedge clk);
      ts[17:15] <= 3'(k);
      ofs[101:85] <= 17'h3;
      repeat (3) @(negedge clk);
      chk("tracked sp6", own[(k-1)*VAL_W +: VAL_W] + 17'h3, thr[101:85]);
    end
    @(posedge clk);
    ts <= {15'h0, 3'h6};
    ofs[16:0] <= 17'h1fffe;
    repeat (3) @(negedge clk);
    chk("tracked sp1", 17'h256, thr[16:0]);
    $display("tracking test done");
  endtask

  task automatic t_sense;
    rst();
    @(posedge clk);
    cm[3:0] <= {CM_HYST, CM_HYST};
    fl <= 6'h03;
    ts[5:3] <= 3'h1;
    ofs[33:17] <= 17'h5;
    bel <= 6'h01;
    lv(17'h67);
    repeat (6) @(negedge clk);
    chk("active", 17'h0, VAL_W'(act));
    lv(17'h6a);
    wr(1, 1'b1, 8);
    chk("active", 17'h2, VAL_W'(act));
    lv(17'h5a);
    wr(0, 1'b1, 8);
    wr(1, 1'b0, 8);
    chk("active", 17'h1, VAL_W'(act));
    // flashing setpoint active, but first half period is six coarse ticks long
    chk("display blank", 17'h0, VAL_W'(blank));
    $display("sense test done");
  endtask

  task automatic t_delays;
    rst();
    @(posedge clk);
    mk[15:0] <= 16'h0001;
    lv(17'h64);
    hd(0, 1'b0, 300);
    lv(17'h0);
    hd(0, 1'b0, 30);
    rst();
    @(posedge clk);
    bk[15:0] <= 16'h0001;
    lv(17'h64);
    wr(0, 1'b1, 8);
    lv(17'h0);
    hd(0, 1'b1, 300);
    $display("delay test done");
  endtask

  task automatic t_modes;
    srt_tmode_t m;
    logic e;
    for (int i = 1; i < 7; i++) begin
      m = srt_tmode_t'(i);
      e = !(m == TM_REPEAT_ON || m == TM_REPEAT_OFF);
      rst();
      @(posedge clk);
      tm[2:0] <= m;
      on[15:0] <= 16'h0001;
      of[15:0] <= 16'h0001;
      bk[15:0] <= 16'h0001;
      lv(17'h64);
      wr(0, 1'b1, 8);
      lv(17'h0);
      repeat (8) @(negedge clk);
      hd(0, e, 300);
    end
    $display("timer mode test done");
  endtask

  task automatic t_pid;
    rst();
    @(posedge clk);
    cm[1:0] <= CM_PID;
    tm[2:0] <= TM_REPEAT_ON;
    pid <= 1'b1;
    wr(0, 1'b1, 8);
    @(posedge clk);
    pid <= 1'b0;
    wr(0, 1'b0, 8);
    @(posedge clk);
    pid <= 1'b1;
    cyc <= 16'h0000;
    hd(0, 1'b0, 40);
    @(posedge clk);
    cyc <= 16'h0001;
    wr(0, 1'b1, 8);
    $display("pid test done");
  endtask

  initial begin
    rst();
    t_decode();
    t_track();
    t_sense();
    t_delays();
    t_modes();
    t_pid();
    test_done();
  end
endmodule
`default_nettype wire
